// >>> design/operating_mode_controller.sv
/*
  Operating-mode and system-clock controller: picks the system clock,
  decides the low-power state entered on halt, and keeps the power-down
  and time-out flags.
  Assumes halt, wake-up and watchdog inputs are one-cycle pulses synchronous
  to the 40 MHz clock, and slow_osc_tick marks each slow oscillator period.
*/
`default_nettype none

module operating_mode_controller
  import opmode_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           nrst,
  input  wire logic [2:0]     addr,
  input  wire logic [7:0]     wdata,
  input  wire logic           wr_en,
  input  wire logic           rd_en,
  output var  logic [7:0]     rdata_ff,
  input  wire logic           halt_exec,
  input  wire logic           wake_event,
  input  wire logic           wdt_timeout,
  input  wire logic           wdt_clear_instr,
  input  wire logic           slow_osc_tick,
  output var  opmode_pkg::op_mode_e mode_ff,
  output var  logic           cpu_run_ff,
  output var  logic           sysclk_tick_ff,
  output var  logic           fast_osc_on_ff,
  output var  logic           fast_div_clocks_on_ff,
  output var  logic           slow_osc_on_ff,
  output var  logic           time_base_on_ff,
  output var  logic           wdt_clear_ff,
  output var  logic           irq_ff
);

  op_mode_e       nxt_mode;
  logic [7:0]     sysmode_ff;
  logic [7:0]     wdog_ctrl_ff;
  logic           power_down_ff;
  logic           timeout_ff;
  logic [2:0]     irq_status_ff;
  logic [2:0]     irq_mask_ff;
  logic [2:0]     irq_event;
  logic           fast_ready;
  logic           ready_prev_ff;
  logic           div_tick;
  logic           fast_sel;
  logic           halt_ok;
  logic           wake_ok;
  logic           low_power;
  logic [2:0]     div_code;
  logic [3:0]     div_exp;

  // ==========================================================
  // Clock selection decode
  always_comb begin
    div_code  = sysmode_ff[SYSMODE_DIV_LSB +: 3];
    fast_sel  = sysmode_ff[SYSMODE_HILO_BIT] || (div_code > DIV_SLOW_LAST);
    div_exp   = sysmode_ff[SYSMODE_HILO_BIT] ? DIV_EXP_FULL : DIV_EXP_OFFSET - {1'b0, div_code};
    low_power = (mode_ff == MODE_SLEEP) || (mode_ff == MODE_IDLE_STOPPED) || (mode_ff == MODE_IDLE_RUNNING);
    halt_ok   = halt_exec && cpu_run_ff;
    wake_ok   = wake_event && low_power;
  end

  // ==========================================================
  // Mode sequencing
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_FAST, MODE_SLOW: begin
        if (halt_ok) begin
          // Only the two idle bits choose the target
          if (!sysmode_ff[SYSMODE_IDLE_BIT]) begin
            nxt_mode = MODE_SLEEP;
          end else if (!wdog_ctrl_ff[WDOG_IDLE_CLK_BIT]) begin
            nxt_mode = MODE_IDLE_STOPPED;
          end else begin
            nxt_mode = MODE_IDLE_RUNNING;
          end
        end else begin
          nxt_mode = fast_sel ? MODE_FAST : MODE_SLOW;
        end
      end
      MODE_SLEEP, MODE_IDLE_STOPPED, MODE_IDLE_RUNNING: begin
        if (wake_ok) begin
          if (!fast_sel) begin
            nxt_mode = MODE_SLOW;
          end else if (fast_ready) begin
            nxt_mode = MODE_FAST;
          end else begin
            nxt_mode = MODE_WAKE_WAIT;
          end
        end
      end
      MODE_WAKE_WAIT: begin
        if (!fast_sel) begin
          nxt_mode = MODE_SLOW;
        end else if (fast_ready) begin
          nxt_mode = MODE_FAST;
        end
      end
      default: nxt_mode = MODE_WAKE_WAIT;
    endcase
  end

  // Power-on waits for the fast oscillator like a wake-up
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode_ff <= MODE_WAKE_WAIT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cpu_run_ff <= 1'b0;
    end else begin
      cpu_run_ff <= (nxt_mode == MODE_FAST) || (nxt_mode == MODE_SLOW);
    end
  end

  // ==========================================================
  // Oscillator and clock enables
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fast_osc_on_ff        <= 1'b0;
      fast_div_clocks_on_ff <= 1'b0;
    end else begin
      // Stopped oscillator also kills its divided taps
      fast_osc_on_ff        <= fast_sel && (nxt_mode != MODE_SLEEP) && (nxt_mode != MODE_IDLE_STOPPED);
      fast_div_clocks_on_ff <= fast_sel && (nxt_mode != MODE_SLEEP) && (nxt_mode != MODE_IDLE_STOPPED);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      slow_osc_on_ff  <= 1'b0;
      time_base_on_ff <= 1'b0;
    end else begin
      slow_osc_on_ff  <= 1'b1;
      time_base_on_ff <= nxt_mode != MODE_SLEEP;
    end
  end

  osc_ready_timer u_ready (
    .clock      (clock),
    .nrst       (nrst),
    .osc_enable (fast_osc_on_ff),
    .ready_ff   (fast_ready)
  );

  sysclk_divider u_div (
    .clock    (clock),
    .nrst     (nrst),
    .run      (fast_ready),
    .exponent (div_exp),
    .tick_ff  (div_tick)
  );

  // No fast-clock tick until the fast oscillator is settled; slow ticks pass in MODE_SLOW
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sysclk_tick_ff <= 1'b0;
    end else begin
      unique case (mode_ff)
        MODE_FAST:         sysclk_tick_ff <= div_tick;
        MODE_SLOW:         sysclk_tick_ff <= slow_osc_tick;
        MODE_IDLE_RUNNING: sysclk_tick_ff <= fast_sel ? div_tick : slow_osc_tick;
        default:           sysclk_tick_ff <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Watchdog clear and status flags; a set wins over a clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wdt_clear_ff <= 1'b0;
    end else begin
      wdt_clear_ff <= halt_ok || wdt_clear_instr;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      power_down_ff <= 1'b0;
      timeout_ff    <= 1'b0;
    end else begin
      power_down_ff <= halt_ok || (power_down_ff && !wdt_clear_instr);
      timeout_ff    <= wdt_timeout || (timeout_ff && !halt_ok && !wdt_clear_instr);
    end
  end

  // ==========================================================
  // Software registers; mode and watchdog writes only land while the CPU runs, mask writes always
  always_ff @(posedge clock) begin
    if (!nrst) begin
      sysmode_ff   <= SYSMODE_RESET;
      wdog_ctrl_ff <= WDOG_RESET;
    end else if (wr_en && cpu_run_ff) begin
      if (addr == ADDR_SYSTEM_MODE) begin
        sysmode_ff <= wdata;
      end
      if (addr == ADDR_WATCHDOG_CTRL) begin
        wdog_ctrl_ff <= wdata;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_mask_ff <= IRQ_MASK_RESET;
    end else if (wr_en && addr == ADDR_IRQ_MASK) begin
      irq_mask_ff <= wdata[IRQ_WIDTH-1:0];
    end
  end

  // ==========================================================
  // Interrupt status, write one to clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ready_prev_ff <= 1'b0;
    end else begin
      ready_prev_ff <= fast_ready;
    end
  end

  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_HALT_BIT]  = halt_ok;
    irq_event[IRQ_WAKE_BIT]  = wake_ok;
    irq_event[IRQ_READY_BIT] = fast_ready && !ready_prev_ff;
  end

  for (genvar i = 0; i < IRQ_WIDTH; i++) begin : g_irq
    always_ff @(posedge clock) begin
      if (!nrst) begin
        irq_status_ff[i] <= 1'b0;
      end else begin
        irq_status_ff[i] <= irq_event[i] ||
                            (irq_status_ff[i] && !(wr_en && addr == ADDR_IRQ_STATUS && wdata[i]));
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ==========================================================
  // Read port, data valid in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        ADDR_SYSTEM_MODE: begin
          rdata_ff                    <= sysmode_ff;
          rdata_ff[SYSMODE_READY_BIT] <= fast_ready;
        end
        ADDR_WATCHDOG_CTRL: rdata_ff <= wdog_ctrl_ff;
        ADDR_STATUS:        rdata_ff <= {6'h00, timeout_ff, power_down_ff};
        ADDR_IRQ_STATUS:    rdata_ff <= {5'h00, irq_status_ff};
        ADDR_IRQ_MASK:      rdata_ff <= {5'h00, irq_mask_ff};
        default:            rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ==========================================================
  // Checks
  a_halt_to_sleep: assert property (@(posedge clock) disable iff (!nrst)
    halt_ok && !sysmode_ff[SYSMODE_IDLE_BIT] |=> mode_ff == MODE_SLEEP && !cpu_run_ff)
    else $error("halt with idle disabled did not enter sleep");
  a_halt_idle_stop: assert property (@(posedge clock) disable iff (!nrst)
    halt_ok && sysmode_ff[SYSMODE_IDLE_BIT] && !wdog_ctrl_ff[WDOG_IDLE_CLK_BIT] |=> mode_ff == MODE_IDLE_STOPPED)
    else $error("halt did not enter clock-stopped idle");
  a_halt_idle_run: assert property (@(posedge clock) disable iff (!nrst)
    halt_ok && sysmode_ff[SYSMODE_IDLE_BIT] && wdog_ctrl_ff[WDOG_IDLE_CLK_BIT] |=> mode_ff == MODE_IDLE_RUNNING)
    else $error("halt did not enter clock-running idle");
  a_halt_flags: assert property (@(posedge clock) disable iff (!nrst)
    halt_ok && !wdt_timeout |=> power_down_ff && !timeout_ff && wdt_clear_ff)
    else $error("halt did not update flags and watchdog");
  a_slow_fast_off: assert property (@(posedge clock) disable iff (!nrst)
    mode_ff == MODE_SLOW |-> !fast_osc_on_ff && !fast_div_clocks_on_ff && time_base_on_ff)
    else $error("fast oscillator running in slow mode");
  a_sleep_stopped: assert property (@(posedge clock) disable iff (!nrst)
    (mode_ff == MODE_SLEEP) [*2] |-> !sysclk_tick_ff && !fast_ready && !time_base_on_ff)
    else $error("clocks running in sleep");
  a_ready_settle: assert property (@(posedge clock) disable iff (!nrst)
    $rose(fast_ready) |-> $past(fast_osc_on_ff, 16) && !$past(fast_ready, 1))
    else $error("ready flag rose before settling");
  a_wait_holds_cpu: assert property (@(posedge clock) disable iff (!nrst)
    mode_ff == MODE_WAKE_WAIT |-> !cpu_run_ff ##0 (!fast_ready || nxt_mode != MODE_WAKE_WAIT))
    else $error("cpu ran before fast oscillator ready");
  a_wake_resume: assert property (@(posedge clock) disable iff (!nrst)
    wake_ok && !fast_sel |=> mode_ff == MODE_SLOW && cpu_run_ff)
    else $error("wake-up did not resume slow mode");
  a_lowpower_halt: assert property (@(posedge clock) disable iff (!nrst)
    low_power |-> !cpu_run_ff && $stable(sysmode_ff))
    else $error("cpu or registers active in low-power mode");

  c_sleep_entry: cover property (@(posedge clock) disable iff (!nrst)
    mode_ff == MODE_FAST ##1 mode_ff == MODE_SLEEP);
  c_idle_running: cover property (@(posedge clock) disable iff (!nrst)
    mode_ff == MODE_IDLE_RUNNING && sysclk_tick_ff);
  c_wake_wait_done: cover property (@(posedge clock) disable iff (!nrst)
    mode_ff == MODE_WAKE_WAIT ##1 mode_ff == MODE_FAST);
  c_fast_to_slow: cover property (@(posedge clock) disable iff (!nrst)
    mode_ff == MODE_FAST ##1 mode_ff == MODE_SLOW);

endmodule

`default_nettype wire

// >>> design/opmode_pkg.sv
/*
  Constants, register map and mode codes of the operating-mode and
  system-clock controller.
  Assumes one 40 MHz reference clock and a synchronous active-low reset.
*/
`default_nettype none

package opmode_pkg;

  // ==========================================================
  // Register map
  localparam logic [2:0] ADDR_SYSTEM_MODE    = 3'h0;
  localparam logic [2:0] ADDR_WATCHDOG_CTRL  = 3'h1;
  localparam logic [2:0] ADDR_STATUS         = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STATUS     = 3'h3;
  localparam logic [2:0] ADDR_IRQ_MASK       = 3'h4;

  // ==========================================================
  // Field positions
  localparam int         SYSMODE_DIV_LSB     = 5;
  localparam int         SYSMODE_READY_BIT   = 2;
  localparam int         SYSMODE_IDLE_BIT    = 1;
  localparam int         SYSMODE_HILO_BIT    = 0;
  localparam int         WDOG_IDLE_CLK_BIT   = 7;
  localparam int         STATUS_PDOWN_BIT    = 0;
  localparam int         STATUS_TIMEOUT_BIT  = 1;
  localparam int         IRQ_WIDTH           = 3;
  localparam int         IRQ_HALT_BIT        = 0;
  localparam int         IRQ_WAKE_BIT        = 1;
  localparam int         IRQ_READY_BIT       = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] SYSMODE_RESET       = 8'h01;
  localparam logic [7:0] WDOG_RESET          = 8'h7a;
  localparam logic [2:0] IRQ_MASK_RESET      = 3'h0;

  // ==========================================================
  // Divider codes and timing
  localparam logic [2:0] DIV_SLOW_LAST       = 3'h1;
  localparam logic [3:0] DIV_EXP_OFFSET      = 4'h8;
  localparam logic [3:0] DIV_EXP_FULL        = 4'h0;
  localparam logic [4:0] OSC_SETTLE_CYCLES   = 5'h10;

  typedef enum logic [2:0] {
    MODE_FAST         = 3'b000,
    MODE_SLOW         = 3'b001,
    MODE_SLEEP        = 3'b010,
    MODE_IDLE_STOPPED = 3'b011,
    MODE_IDLE_RUNNING = 3'b100,
    MODE_WAKE_WAIT    = 3'b101
  } op_mode_e;

endpackage

`default_nettype wire

// >>> design/osc_ready_timer.sv
/*
  Start-up timer of the fast oscillator: raises the ready flag once the
  oscillator has been enabled for the settling count.
  Assumes the enable comes from a flip-flop of the same clock.
*/
`default_nettype none

module osc_ready_timer
  import opmode_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic osc_enable,
  output var  logic ready_ff
);

  logic [4:0] settle_cnt_ff;

  // ==========================================================
  // Settling count, restarted whenever the oscillator is off
  always_ff @(posedge clock) begin
    if (!nrst || !osc_enable) begin
      settle_cnt_ff <= 5'h00;
    end else if (settle_cnt_ff != OSC_SETTLE_CYCLES) begin
      settle_cnt_ff <= settle_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst || !osc_enable) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= (settle_cnt_ff == OSC_SETTLE_CYCLES - 5'h01) || ready_ff;
    end
  end

endmodule

`default_nettype wire

// >>> design/sysclk_divider.sv
/*
  Fast-clock divider: a one-cycle tick every 2**exponent cycles.
  Assumes the exponent is stable while run is high; counting restarts at run.
*/
`default_nettype none

module sysclk_divider (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [3:0] exponent,
  output var  logic       tick_ff
);

  logic [5:0] div_cnt_ff;
  logic [6:0] span;
  logic [5:0] mask;

  always_comb begin
    span = (7'h01 << exponent) - 7'h01;
    mask = span[5:0];
  end

  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      div_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end

  // Exponent 0 gives a tick every cycle, 6 one in 64
  always_ff @(posedge clock) begin
    if (!nrst || !run) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= (div_cnt_ff & mask) == mask;
    end
  end

endmodule

`default_nettype wire

// >>> sim/operating_mode_controller_bench.sv
/*
  Self-checking bench of the operating-mode controller: register access,
  clock selection, divider ratios, halt and wake-up through every mode.
  Assumes the package and design files are compiled first; the bench drives
  every input itself and models no far-side device.
*/
`default_nettype none

module operating_mode_controller_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import opmode_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  logic       clock           = 1'b0;
  logic       nrst            = 1'b0;
  logic [2:0] addr            = 3'h0;
  logic [7:0] wdata           = 8'h00;
  logic       wr_en           = 1'b0;
  logic       rd_en           = 1'b0;
  logic       halt_exec       = 1'b0;
  logic       wake_event      = 1'b0;
  logic       wdt_timeout     = 1'b0;
  logic       wdt_clear_instr = 1'b0;
  logic       slow_osc_tick   = 1'b0;
  logic [2:0] slow_cnt        = 3'h0;
  logic [7:0] rdata_ff;
  op_mode_e   mode_ff;
  logic       cpu_run_ff;
  logic       sysclk_tick_ff;
  logic       fast_osc_on_ff;
  logic       fast_div_clocks_on_ff;
  logic       slow_osc_on_ff;
  logic       time_base_on_ff;
  logic       wdt_clear_ff;
  logic       irq_ff;
  int         err_total   = 0;
  int         comparisons = 0;

  always #12.5 clock = ~clock;

  // Slow oscillator period of eight reference cycles
  always @(posedge clock) begin
    slow_cnt      <= slow_cnt + 3'h1;
    slow_osc_tick <= (slow_cnt == 3'h7);
  end

  operating_mode_controller u_operating_mode_controller (
    .clock                 (clock),
    .nrst                  (nrst),
    .addr                  (addr),
    .wdata                 (wdata),
    .wr_en                 (wr_en),
    .rd_en                 (rd_en),
    .rdata_ff              (rdata_ff),
    .halt_exec             (halt_exec),
    .wake_event            (wake_event),
    .wdt_timeout           (wdt_timeout),
    .wdt_clear_instr       (wdt_clear_instr),
    .slow_osc_tick         (slow_osc_tick),
    .mode_ff               (mode_ff),
    .cpu_run_ff            (cpu_run_ff),
    .sysclk_tick_ff        (sysclk_tick_ff),
    .fast_osc_on_ff        (fast_osc_on_ff),
    .fast_div_clocks_on_ff (fast_div_clocks_on_ff),
    .slow_osc_on_ff        (slow_osc_on_ff),
    .time_base_on_ff       (time_base_on_ff),
    .wdt_clear_ff          (wdt_clear_ff),
    .irq_ff                (irq_ff)
  );

  // ==========================================================
  // Compare, bus and pulse helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_mode(input op_mode_e exp);
    chk({5'h0, mode_ff}, {5'h0, exp});
  endtask

  // Returns one edge after the taking edge: mode and enables follow the
  // register a cycle later, so checks made on return see the new state
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(rdata_ff, exp);
  endtask

  // 0 halt, 1 wake, 2 watchdog time-out, 3 clear-watchdog instruction
  task automatic hit(input logic [1:0] k);
    @(posedge clock);
    case (k)
      2'h0: halt_exec <= 1'b1;
      2'h1: wake_event <= 1'b1;
      2'h2: wdt_timeout <= 1'b1;
      default: wdt_clear_instr <= 1'b1;
    endcase
    @(posedge clock);
    halt_exec       <= 1'b0;
    wake_event      <= 1'b0;
    wdt_timeout     <= 1'b0;
    wdt_clear_instr <= 1'b0;
    #1;
  endtask

  // Bounded wait so a CPU that never restarts cannot hang the run
  task automatic wait_run(output int n);
    n = 0;
    while (cpu_run_ff !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1 n++;
    end
  endtask

  task automatic ticks(input int m, output int t);
    t = 0;
    repeat (m) begin
      @(posedge clock);
      #1 if (sysclk_tick_ff === 1'b1) t++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    int n;
    wait_run(n);
    chk_mode(MODE_FAST);
    chk({4'h0, slow_osc_on_ff, time_base_on_ff, fast_osc_on_ff, fast_div_clocks_on_ff}, 8'h0f);
    rchk(ADDR_SYSTEM_MODE, 8'h05);
    rchk(ADDR_WATCHDOG_CTRL, WDOG_RESET);
    rchk(ADDR_STATUS, 8'h00);
    rchk(3'h5, 8'h00);
  endtask

  task automatic t_slow();
    int t;
    wr(ADDR_SYSTEM_MODE, 8'h00);
    chk_mode(MODE_SLOW);
    chk({4'h0, fast_osc_on_ff, fast_div_clocks_on_ff, slow_osc_on_ff, time_base_on_ff}, 8'h03);
    ticks(64, t);
    chk(8'(t), 8'h08);
    wr(ADDR_SYSTEM_MODE, 8'h20);
    chk_mode(MODE_SLOW);
    rchk(ADDR_SYSTEM_MODE, 8'h20);
    wr(ADDR_SYSTEM_MODE, 8'h40);
    chk_mode(MODE_FAST);
    chk({4'h0, fast_osc_on_ff, fast_div_clocks_on_ff, slow_osc_on_ff, time_base_on_ff}, 8'h0f);
    rchk(ADDR_SYSTEM_MODE, 8'h40);
    repeat (20) @(posedge clock);
    rchk(ADDR_SYSTEM_MODE, 8'h44);
  endtask

  task automatic t_div();
    int t;
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_SYSTEM_MODE, (i == 0) ? 8'h01 : 8'((i + 1) << 5));
      repeat (4) @(posedge clock);
      ticks(128, t);
      chk(8'(t), 8'((i == 0) ? 128 : (1 << i)));
    end
  endtask

  task automatic t_sleep();
    int n;
    int t;
    wr(ADDR_SYSTEM_MODE, 8'h01);
    hit(2'h2);
    rchk(ADDR_STATUS, 8'h02);
    hit(2'h0);
    chk_mode(MODE_SLEEP);
    chk({2'h0, cpu_run_ff, wdt_clear_ff, time_base_on_ff, fast_osc_on_ff, fast_div_clocks_on_ff, slow_osc_on_ff},
        8'h11);
    rchk(ADDR_STATUS, 8'h01);
    rchk(ADDR_SYSTEM_MODE, 8'h01);
    wr(ADDR_SYSTEM_MODE, 8'h00);
    rchk(ADDR_SYSTEM_MODE, 8'h01);
    ticks(16, t);
    chk(8'(t), 8'h00);
    hit(2'h1);
    chk_mode(MODE_WAKE_WAIT);
    chk({7'h0, fast_osc_on_ff}, 8'h01);
    wait_run(n);
    chk({7'h0, n >= 16 && n <= 17}, 8'h01);
    chk_mode(MODE_FAST);
  endtask

  task automatic t_idle();
    logic [7:0] sm [3] = '{8'h03, 8'h03, 8'h02};
    logic [7:0] wd [3] = '{8'h7a, 8'hfa, 8'hfa};
    op_mode_e   lp [3] = '{MODE_IDLE_STOPPED, MODE_IDLE_RUNNING, MODE_IDLE_RUNNING};
    op_mode_e   bk [3] = '{MODE_FAST, MODE_FAST, MODE_SLOW};
    int         tk [3] = '{0, 16, 2};
    int         n;
    int         t;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_WATCHDOG_CTRL, wd[i]);
      wr(ADDR_SYSTEM_MODE, sm[i]);
      hit(2'h0);
      chk_mode(lp[i]);
      chk({5'h0, time_base_on_ff, fast_osc_on_ff, cpu_run_ff}, {5'h0, 1'b1, (i == 1), 1'b0});
      ticks(16, t);
      chk(8'(t), 8'(tk[i]));
      hit(2'h1);
      wait_run(n);
      chk_mode(bk[i]);
    end
  endtask

  task automatic t_irq();
    wr(ADDR_IRQ_STATUS, 8'h07);
    rchk(ADDR_IRQ_STATUS, 8'h00);
    hit(2'h0);
    hit(2'h1);
    rchk(ADDR_IRQ_STATUS, 8'h03);
    chk({7'h0, irq_ff}, 8'h00);
    wr(ADDR_IRQ_MASK, 8'h02);
    @(posedge clock);
    #1 chk({7'h0, irq_ff}, 8'h01);
    wr(ADDR_IRQ_STATUS, 8'h02);
    @(posedge clock);
    #1 chk({7'h0, irq_ff}, 8'h00);
    rchk(ADDR_IRQ_STATUS, 8'h01);
    rchk(ADDR_IRQ_MASK, 8'h02);
    hit(2'h3);
    chk({7'h0, wdt_clear_ff}, 8'h01);
    rchk(ADDR_STATUS, 8'h00);
    wr(ADDR_SYSTEM_MODE, 8'h01);
    repeat (20) @(posedge clock);
    rchk(ADDR_IRQ_STATUS, 8'h05);
  endtask

  // ==========================================================
  // Sequence, watchdog and verdict
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_slow();
    t_div();
    t_sleep();
    t_idle();
    t_irq();
    results();
  end

  // The tests need about 1300 cycles; this leaves ample margin
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    results();
  end
endmodule

`default_nettype wire
